// *** gms_pkg.sv ***
// Purpose: Shared constants and types of the operating-mode sequencer
// Assumes: 250 MHz system clock, one-second timebase derived from it
// Notes: Register map of the AXI4-Lite slave lives here
package gms_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ = 250000000;
	localparam int GLOW_PHASE_INDICATION_S = 10;
	localparam int GLOW_PHASE_INDICATION_COLD_S = 40;
	localparam int OVERRIDE_S = 10;
	localparam int AUTO_DELAY_S = 5;
	localparam int CRANK_S = 5;
	localparam int STOP_S = 3;
	localparam int COOLDOWN_S = 120;
	localparam int SVC_EXT_PCT = 30;
	localparam int SVC_EXT_MAX_H = 200;
	localparam int INV_TRIP_C = 75;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] SVC_OFS = 8'h08;
	localparam logic [7:0] TEMP_OFS = 8'h0c;
	localparam logic [7:0] SVCX_OFS = 8'h10;
	localparam int CTRL_AUTO_BIT = 0;
	localparam int CTRL_THREE_PH_BIT = 1;
	localparam int CTRL_DYN_BIT = 2;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] SVC_RST = 16'h01f4;
	localparam logic [7:0] COOL_RST = 8'h78;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [3:0] {
		ST_OFF = 4'h0,
		ST_STANDBY = 4'h1,
		ST_GLOW_PHASE_INDICATION = 4'h3,
		ST_CRANK = 4'h2,
		ST_OVERRIDE = 4'h6,
		ST_RUN = 4'h7,
		ST_COOLDOWN = 4'h5,
		ST_STOP = 4'h4,
		ST_FAIL = 4'hc
	} gms_state_e;

	typedef enum logic [3:0] {
		IND_OFF = 4'h0,
		IND_STANDBY = 4'h1,
		IND_GLOW_PHASE_INDICATION = 4'h2,
		IND_STARTING = 4'h3,
		IND_OVERRIDE = 4'h4,
		IND_RUNNING = 4'h5,
		IND_AUTOSTART = 4'h6,
		IND_STOPPING = 4'h7,
		IND_CRANK_FAIL = 4'h8,
		IND_COOLDOWN = 4'h9
	} gms_ind_e;

	typedef enum logic [2:0] {
		SCR_DEFAULT = 3'h0,
		SCR_SERVICE = 3'h1,
		SCR_INV0 = 3'h2
	} gms_scr_e;

	typedef struct packed {
		logic power;
		logic start_stop;
		logic up;
		logic down;
	} gms_btn_s;

	typedef struct packed {
		logic glow;
		logic starter;
		logic fuel_run;
		logic speed_max;
		logic speed_idle;
		logic inverter_en;
		logic fault_eval_en;
	} gms_act_s;

	typedef struct packed {
		logic engine_running;
		logic below_freezing;
		logic head_overtemp;
		logic clutch_engaged;
	} gms_sense_s;

endpackage

// *** gms_btn_sync.sv ***
// Purpose: Two-stage synchroniser and rising-edge detector per input
// Assumes: Inputs are debounced switch levels from outside the clock domain
// Notes: Stage one feeds only stage two
`timescale 1ns/1ps
module gms_btn_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Raw levels
	input wire logic [W-1:0] raw,
	// Synchronised level and one-cycle press event
	output logic [W-1:0] level,
	output logic [W-1:0] press
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;
	logic [W-1:0] prev_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= '0;
			sync_r <= '0;
			prev_r <= '0;
		end else begin
			meta_r <= raw;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level = sync_r;
	assign press = sync_r & ~prev_r;
endmodule

// *** gms_sequencer.sv ***
// Operation
// R1 - Power-on enters stand-by with stand-by indication
// R2 - Stand-by: power turns off, start/stop starts
// R3 - Stand-by cursor toggles service screen
// R4 - Dynamic hours extend service 30 percent, 200h
// R5 - Pre-heat ten seconds, shown as pre-heat
// R6 - Below freezing pre-heat lasts forty seconds
// R7 - After pre-heat energise starter, show starting
// R8 - One crank attempt, failure shown, no retry
// R9 - Cursor or start/stop clears failure
// R10 - Override ten seconds, faults suppressed
// R11 - Running state shows running and load
// R12 - Cursor-up steps one or five inverter screens
// R13 - Inverter off at board 75 degrees
// R14 - Clutch engaged raises speed to maximum
// R15 - Start/stop in run stops, then stand-by
// R16 - Hot head stop starts cool-down countdown
// R17 - Cool-down disables inverter, engine idles
// R18 - Cool-down ignores automatic start requests
// R19 - Cool-down expiry or press stops engine
// R20 - Held start request starts after five seconds
// R21 - Released request stops after five seconds
// R22 - Autostart flag persists, shown instead of stand-by
// R23 - Manual start-stop in autostart drops autostart
// R24 - Status field shows every operating state
// R25 - Durations timed by divided one-second tick
// R26 - Buttons synchronised, one press one event
//
// Purpose: Operating-mode sequencer of a generator set controller
// Assumes: Autostart flag comes from nonvolatile storage via an input
// Notes: AXI4-Lite slave exposes control and status
`timescale 1ns/1ps
module gms_sequencer
	import gms_pkg::*;
#(
	parameter int TICK_CYCLES = CLK_HZ,
	parameter int COOL_SECONDS = COOLDOWN_S,
	parameter int CRANK_SECONDS = CRANK_S
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Front panel
	input wire gms_btn_s buttons,
	// Sensors and external request
	input wire gms_sense_s sense,
	input wire logic external_start_request_input,
	input wire logic [7:0] inverter_board_temp,
	input wire logic [6:0] load_percent,
	input wire logic autostart_nv,
	// Actuators and panel
	output gms_act_s act,
	output logic controller_on,
	output gms_ind_e status_ind,
	output gms_scr_e screen,
	output logic [7:0] countdown,
	output logic [6:0] load_bar,
	output logic autostart_nv_clear,
	// AXI4-Lite slave
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready
);

	// ************************************************************
	// Input synchronisation
	// ************************************************************
	localparam int NIN = 9;
	logic [NIN-1:0] lvl;
	logic [NIN-1:0] prs;
	gms_btn_sync #(.W(NIN)) u_sync ( // R26
		.aclk(aclk),
		.aresetn(aresetn),
		.raw({buttons, sense, external_start_request_input}),
		.level(lvl),
		.press(prs)
	);
	logic p_pwr, p_ss, p_up, p_dn;
	logic run_ok, cold, hot, clutch, req;
	assign p_pwr = prs[8];
	assign p_ss = prs[7];
	assign p_up = prs[6];
	assign p_dn = prs[5];
	assign run_ok = lvl[4];
	assign cold = lvl[3];
	assign hot = lvl[2];
	assign clutch = lvl[1];
	assign req = lvl[0];

	// ************************************************************
	// One-second tick
	// ************************************************************
	logic [31:0] div_r;
	logic tick;
	assign tick = (div_r == 32'(TICK_CYCLES - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn)
			div_r <= '0;
		else if (tick)
			div_r <= '0; // R25
		else
			div_r <= div_r + 32'h1;
	end

	// ************************************************************
	// Registers
	// ************************************************************
	logic [31:0] ctrl_r;
	logic [15:0] svc_r;
	logic [7:0] cool_r;
	logic auto_r, auto_ld_r, manual_r;
	logic [15:0] svc_ext;

	function automatic logic [15:0] svc_limit(input logic [15:0] base,
		input logic dyn);
		logic [31:0] ext;
		ext = (32'(base) * 32'(SVC_EXT_PCT)) / 32'd100;
		if (ext > 32'(SVC_EXT_MAX_H))
			ext = 32'(SVC_EXT_MAX_H);
		svc_limit = dyn ? 16'(32'(base) + ext) : base; // R4
	endfunction
	assign svc_ext = svc_limit(svc_r, ctrl_r[CTRL_DYN_BIT]);

	// ************************************************************
	// Sequencer
	// ************************************************************
	gms_state_e st_r, st_nxt;
	logic [7:0] tmr_r, tmr_nxt;
	logic [7:0] aut_r;
	logic auto_go, auto_stop;

	// Autostart debounce: count seconds while request disagrees with state
	always_ff @(posedge aclk) begin
		if (!aresetn)
			aut_r <= '0;
		else if (!auto_r || manual_r || (req == (st_r != ST_STANDBY)))
			aut_r <= '0;
		else if (tick && aut_r < 8'(AUTO_DELAY_S))
			aut_r <= aut_r + 8'h1; // R20 R21
	end
	assign auto_go = auto_r && req && st_r == ST_STANDBY &&
		aut_r == 8'(AUTO_DELAY_S); // R18 R20
	assign auto_stop = auto_r && !req && aut_r == 8'(AUTO_DELAY_S); // R21

	always_comb begin
		st_nxt = st_r;
		tmr_nxt = (tick && tmr_r != 8'h0) ? tmr_r - 8'h1 : tmr_r;
		case (st_r)
			ST_OFF: begin
				if (p_pwr)
					st_nxt = ST_STANDBY; // R1
			end
			ST_STANDBY: begin
				if (p_pwr)
					st_nxt = ST_OFF; // R2
				else if (p_ss || auto_go) begin
					st_nxt = ST_GLOW_PHASE_INDICATION; // R2 R5
					tmr_nxt = cold ? 8'(GLOW_PHASE_INDICATION_COLD_S)
						: 8'(GLOW_PHASE_INDICATION_S); // R6
				end
			end
			ST_GLOW_PHASE_INDICATION: begin
				if (tmr_r == 8'h0) begin
					st_nxt = ST_CRANK; // R7
					tmr_nxt = 8'(CRANK_SECONDS);
				end
			end
			ST_CRANK: begin
				if (run_ok) begin
					st_nxt = ST_OVERRIDE; // R10
					tmr_nxt = 8'(OVERRIDE_S);
				end else if (tmr_r == 8'h0)
					st_nxt = ST_FAIL; // R8
			end
			ST_FAIL: begin
				if (p_up || p_dn || p_ss)
					st_nxt = ST_STANDBY; // R9
			end
			ST_OVERRIDE: begin
				if (tmr_r == 8'h0)
					st_nxt = ST_RUN; // R11
			end
			ST_RUN: begin
				if (p_ss || auto_stop) begin
					if (hot) begin
						st_nxt = ST_COOLDOWN; // R16
						tmr_nxt = 8'(COOL_SECONDS);
					end else begin
						st_nxt = ST_STOP; // R15
						tmr_nxt = 8'(STOP_S);
					end
				end
			end
			ST_COOLDOWN: begin
				if (p_ss || tmr_r == 8'h0) begin
					st_nxt = ST_STOP; // R19
					tmr_nxt = 8'(STOP_S);
				end
			end
			ST_STOP: begin
				if (tmr_r == 8'h0 && !run_ok)
					st_nxt = ST_STANDBY; // R15
			end
			default: st_nxt = ST_OFF;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= ST_OFF;
			tmr_r <= '0;
		end else begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt; // R25
		end
	end

	// Manual start tracking, autostart flag load and fallback
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			auto_r <= 1'b0;
			auto_ld_r <= 1'b0;
			manual_r <= 1'b0;
		end else begin
			auto_ld_r <= 1'b1;
			if (!auto_ld_r)
				auto_r <= autostart_nv; // R22
			else if (st_r == ST_STOP && st_nxt == ST_STANDBY && manual_r)
				auto_r <= 1'b0; // R23
			else if (st_r == ST_OFF && st_nxt == ST_STANDBY)
				auto_r <= autostart_nv | ctrl_r[CTRL_AUTO_BIT];
			if (st_r == ST_STANDBY)
				manual_r <= p_ss && st_nxt == ST_GLOW_PHASE_INDICATION;
		end
	end
	assign autostart_nv_clear = 1'b0;

	// ************************************************************
	// Screen navigation
	// ************************************************************
	logic [2:0] inv_n;
	assign inv_n = ctrl_r[CTRL_THREE_PH_BIT] ? 3'h5 : 3'h1;
	always_ff @(posedge aclk) begin
		if (!aresetn || st_r != st_nxt)
			screen <= SCR_DEFAULT;
		else if (st_r == ST_STANDBY && (p_up || p_dn))
			screen <= (screen == SCR_DEFAULT) ? SCR_SERVICE
				: SCR_DEFAULT; // R3
		else if (st_r == ST_RUN && p_up) begin
			if (screen == SCR_DEFAULT)
				screen <= SCR_INV0; // R12
			else if (screen - SCR_INV0 + 3'h1 >= inv_n)
				screen <= SCR_DEFAULT;
			else
				screen <= gms_scr_e'(screen + 3'h1); // R12
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	logic inv_hot;
	assign inv_hot = inverter_board_temp >= 8'(INV_TRIP_C);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act <= '0;
			controller_on <= 1'b0;
			status_ind <= IND_OFF;
			countdown <= '0;
			load_bar <= '0;
		end else begin
			controller_on <= st_r != ST_OFF;
			act.glow <= st_r == ST_GLOW_PHASE_INDICATION; // R5
			act.starter <= st_r == ST_CRANK; // R7
			act.fuel_run <= st_r inside {ST_CRANK, ST_OVERRIDE,
				ST_RUN, ST_COOLDOWN};
			act.fault_eval_en <= st_r == ST_RUN; // R10
			act.speed_idle <= st_r == ST_COOLDOWN; // R17
			act.speed_max <= st_r == ST_RUN && clutch; // R14
			act.inverter_en <= st_r == ST_RUN && !inv_hot; // R13 R17
			load_bar <= (st_r == ST_RUN) ? load_percent : 7'h0; // R11
			countdown <= (st_r == ST_COOLDOWN) ? tmr_r : 8'h0; // R16
			case (st_r) // R24
				ST_STANDBY: status_ind <= auto_r ? IND_AUTOSTART
					: IND_STANDBY; // R1 R22
				ST_GLOW_PHASE_INDICATION: status_ind <= IND_GLOW_PHASE_INDICATION;
				ST_CRANK: status_ind <= IND_STARTING;
				ST_FAIL: status_ind <= IND_CRANK_FAIL; // R8
				ST_OVERRIDE: status_ind <= IND_OVERRIDE;
				ST_RUN: status_ind <= IND_RUNNING;
				ST_COOLDOWN: status_ind <= IND_COOLDOWN;
				ST_STOP: status_ind <= IND_STOPPING;
				default: status_ind <= IND_OFF;
			endcase
		end
	end

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	logic aw_r, w_r;
	logic [7:0] awa_r;
	logic [31:0] wd_r;
	logic [3:0] ws_r;
	assign s_awready = !aw_r && !s_bvalid;
	assign s_wready = !w_r && !s_bvalid;
	assign s_arready = !s_rvalid;

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			if (be[i])
				o[8*i +: 8] = d[8*i +: 8];
		merge = o;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_r <= 1'b0;
			w_r <= 1'b0;
			awa_r <= '0;
			wd_r <= '0;
			ws_r <= '0;
			s_bvalid <= 1'b0;
			s_bresp <= 2'h0;
			ctrl_r <= CTRL_RST;
			svc_r <= SVC_RST;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_r <= 1'b1;
				awa_r <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_r <= 1'b1;
				wd_r <= s_wdata;
				ws_r <= s_wstrb;
			end
			if (aw_r && w_r) begin
				aw_r <= 1'b0;
				w_r <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= 2'h0;
				if (awa_r == CTRL_OFS)
					ctrl_r <= merge(ctrl_r, wd_r, ws_r);
				else if (awa_r == SVC_OFS)
					svc_r <= 16'(merge({16'h0, svc_r}, wd_r, ws_r));
				else
					s_bresp <= 2'h2;
			end else if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata <= '0;
			s_rresp <= 2'h0;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rresp <= 2'h0;
			case (s_araddr)
				CTRL_OFS: s_rdata <= ctrl_r;
				STAT_OFS: s_rdata <= {8'h0, countdown, 8'h0, auto_r,
					screen, status_ind};
				SVC_OFS: s_rdata <= {16'h0, svc_r};
				TEMP_OFS: s_rdata <= {24'h0, inverter_board_temp};
				SVCX_OFS: s_rdata <= {16'h0, svc_ext};
				default: begin
					s_rdata <= '0;
					s_rresp <= 2'h2;
				end
			endcase
		end else if (s_rvalid && s_rready)
			s_rvalid <= 1'b0;
	end
endmodule

// *** gms_chk.sv ***
// Purpose: Port assertions of the operating-mode sequencer
// Assumes: Bound to gms_sequencer, one clock domain
// Notes: Registered outputs may lag each other by one edge
`timescale 1ns/1ps
module gms_chk
	import gms_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Plant side
	input wire gms_act_s act,
	input wire gms_sense_s sense,
	input wire gms_ind_e status_ind,
	input wire logic [7:0] inverter_board_temp,
	input wire logic [6:0] load_percent,
	input wire logic [6:0] load_bar,
	// Register bus
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic s_rvalid
);
	// ************************************************************
	// Properties
	// ************************************************************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_in(gms_ind_e v);
		(status_ind == v) [*2];
	endsequence
	property p_glow;
		s_in(IND_GLOW_PHASE_INDICATION) |-> act.glow && !act.starter;
	endproperty
	a_glow: assert property (p_glow) else $error("glow wrong");
	property p_crank;
		s_in(IND_STARTING) |-> act.starter && !act.glow;
	endproperty
	a_crank: assert property (p_crank) else $error("crank wrong");
	property p_fail;
		s_in(IND_CRANK_FAIL) |-> !act.starter && !act.glow;
	endproperty
	a_fail: assert property (p_fail) else $error("retry seen");
	property p_ovr;
		s_in(IND_OVERRIDE) |-> !act.fault_eval_en;
	endproperty
	a_ovr: assert property (p_ovr) else $error("faults on");
	property p_bar;
		s_in(IND_RUNNING) |-> load_bar == $past(load_percent);
	endproperty
	a_bar: assert property (p_bar) else $error("bar wrong");
	property p_nobar;
		s_in(IND_STANDBY) |-> load_bar == 7'h00;
	endproperty
	a_nobar: assert property (p_nobar) else $error("idle bar");
	property p_hot;
		(inverter_board_temp >= 8'h4b) [*2] |-> !act.inverter_en;
	endproperty
	a_hot: assert property (p_hot) else $error("inverter hot");
	property p_cool;
		s_in(IND_COOLDOWN) |-> !act.inverter_en && act.speed_idle;
	endproperty
	a_cool: assert property (p_cool) else $error("cool wrong");
	property p_clutch;
		(sense.clutch_engaged && status_ind == IND_RUNNING) [*6]
			|-> act.speed_max;
	endproperty
	a_clutch: assert property (p_clutch) else $error("no boost");
	property p_b;
		s_bvalid && !s_bready |=> s_bvalid;
	endproperty
	a_b: assert property (p_b) else $error("bvalid dropped");
	property p_r;
		s_arvalid && s_arready |=> s_rvalid;
	endproperty
	a_r: assert property (p_r) else $error("rvalid late");
endmodule
bind gms_sequencer gms_chk u_chk (.aclk(aclk), .aresetn(aresetn),
	.act(act), .sense(sense), .status_ind(status_ind),
	.inverter_board_temp(inverter_board_temp),
	.load_percent(load_percent), .load_bar(load_bar),
	.s_bvalid(s_bvalid), .s_bready(s_bready), .s_arvalid(s_arvalid),
	.s_arready(s_arready), .s_rvalid(s_rvalid));

// *** gms_eng.sv ***
// Purpose: Engine and sensor model facing the actuators
// Assumes: Engine catches after 20 cranking cycles when allowed
// Notes: Running stops once fuel and starter are both off
`timescale 1ns/1ps
module gms_eng
	import gms_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Actuators and scenario levels
	input wire gms_act_s act,
	input wire logic start_ok,
	input wire logic cold,
	input wire logic hot,
	input wire logic clutch,
	// Sensor flags
	output gms_sense_s sense
);
	// ************************************************************
	// Engine
	// ************************************************************
	logic run_r;
	logic [4:0] crank_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crank_r <= 5'h00;
			run_r <= 1'b0;
		end else begin
			crank_r <= act.starter ? crank_r + 5'h01 : 5'h00;
			if (act.starter && start_ok && crank_r == 5'h14)
				run_r <= 1'b1;
			else if (!act.fuel_run && !act.starter)
				run_r <= 1'b0;
		end
	end
	assign sense = '{run_r, cold, hot, clutch};
endmodule

// *** tb.sv ***
// Purpose: Self-checking bench of the operating-mode sequencer
// Assumes: One tick is ten clock cycles
// Notes: Buttons are held long enough to pass the synchroniser
`timescale 1ns/1ps
module tb;
	import gms_pkg::*;
	localparam int T = 10;
	localparam int COOL = 8;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	gms_btn_s btn = '0;
	gms_sense_s sense;
	logic req = 1'b0, ok = 1'b0, cold = 1'b0, hot = 1'b0, clu = 1'b0;
	logic [7:0] temp = 8'h14, awa = 8'h00, ara = 8'h00, cd;
	logic [6:0] load = 7'h2a, bar;
	logic [31:0] wd = 32'h0, rd, x;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic con, awr, wr, bv, arr, rv;
	logic [1:0] br, rr, rs;
	gms_act_s act;
	gms_ind_e ind;
	gms_scr_e scr;
	int n_errors = 0, n_compared = 0, cyc = 0, n;
	always #2 aclk = ~aclk;
	gms_sequencer #(.TICK_CYCLES(T), .COOL_SECONDS(COOL),
		.CRANK_SECONDS(CRANK_S)) dut (.aclk(aclk), .aresetn(aresetn),
		.buttons(btn), .sense(sense), .external_start_request_input(req),
		.inverter_board_temp(temp), .load_percent(load),
		.autostart_nv(1'b0), .act(act), .controller_on(con),
		.status_ind(ind), .screen(scr), .countdown(cd), .load_bar(bar),
		.autostart_nv_clear(), .s_awaddr(awa), .s_awvalid(awv),
		.s_awready(awr), .s_wdata(wd), .s_wstrb(4'hf), .s_wvalid(wv),
		.s_wready(wr), .s_bresp(br), .s_bvalid(bv), .s_bready(bry),
		.s_araddr(ara), .s_arvalid(arv), .s_arready(arr), .s_rdata(rd),
		.s_rresp(rr), .s_rvalid(rv), .s_rready(rry));
	gms_eng eng (.aclk(aclk), .aresetn(aresetn), .act(act),
		.start_ok(ok), .cold(cold), .hot(hot), .clutch(clu), .sense(sense));
	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic test_done;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(string s, logic [31:0] g, logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	function automatic logic inr(int k, int s);
		return k >= (s - 1) * T - 20 && k <= (s + 1) * T;
	endfunction
	task automatic w(int k);
		repeat (k) @(posedge aclk);
	endtask
	task automatic press(int b);
		btn <= gms_btn_s'(4'h1 << b);
		w(8);
		btn <= '0;
		w(8);
	endtask
	task automatic wi(gms_ind_e v, output int k);
		k = 0;
		while (ind !== v && k < 3000) begin
			@(posedge aclk);
			k++;
		end
		chk("status", ind, v);
	endtask
	task automatic ax(bit wt, logic [7:0] a, logic [31:0] d);
		if (wt) begin
			awa <= a;
			wd <= d;
			awv <= 1'b1;
			wv <= 1'b1;
			bry <= 1'b1;
		end else begin
			ara <= a;
			arv <= 1'b1;
			rry <= 1'b1;
		end
		do begin
			@(posedge aclk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr)
				wv <= 1'b0;
			if (arv && arr)
				arv <= 1'b0;
		end while (!(wt ? bv && bry : rv && rry));
		rs = wt ? br : rr;
		x = rd;
		bry <= 1'b0;
		rry <= 1'b0;
		@(posedge aclk);
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			test_done();
		end
	end
	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		w(12);
		aresetn <= 1'b1;
		w(2);
		press(3);
		wi(IND_STANDBY, n);
		chk("on", con, 1);
		press(1);
		chk("screen", scr, SCR_SERVICE);
		press(0);
		chk("screen", scr, SCR_DEFAULT);
		ax(0, CTRL_OFS, 0);
		chk("ctrl", x, CTRL_RST);
		ax(0, SVC_OFS, 0);
		chk("svc", x, {16'h0, SVC_RST});
		ax(0, 8'h40, 0);
		chk("resp", rs, 2'h2);
		ax(1, STAT_OFS, 0);
		chk("resp", rs, 2'h2);
		ax(1, CTRL_OFS, 32'h6);
		ax(0, SVCX_OFS, 0);
		chk("svcx", x, 32'd650);
		ax(1, SVC_OFS, 32'd1000);
		ax(0, SVCX_OFS, 0);
		chk("svcx", x, 32'd1200);
		ax(0, TEMP_OFS, 0);
		chk("temp", x, {24'h0, temp});
		$display("test idle done");
		press(2);
		wi(IND_GLOW_PHASE_INDICATION, n);
		wi(IND_STARTING, n);
		chk("glow_phase_indication", inr(n, GLOW_PHASE_INDICATION_S), 1);
		wi(IND_CRANK_FAIL, n);
		chk("crank", inr(n, CRANK_S), 1);
		w(200);
		chk("starter", act.starter, 0);
		press(0);
		wi(IND_STANDBY, n);
		$display("test fail done");
		ok <= 1'b1;
		cold <= 1'b1;
		press(2);
		wi(IND_GLOW_PHASE_INDICATION, n);
		wi(IND_STARTING, n);
		chk("glow_phase_indication", inr(n, GLOW_PHASE_INDICATION_COLD_S), 1);
		wi(IND_OVERRIDE, n);
		wi(IND_RUNNING, n);
		chk("override", inr(n, OVERRIDE_S), 1);
		w(4);
		chk("faults", act.fault_eval_en, 1);
		chk("bar", bar, load);
		press(1);
		chk("screen", scr, SCR_INV0);
		repeat (4) press(1);
		chk("screen", scr, 3'h6);
		press(1);
		chk("screen", scr, SCR_DEFAULT);
		temp <= 8'h4b;
		w(4);
		chk("inv", act.inverter_en, 0);
		temp <= 8'h4a;
		w(4);
		chk("inv", act.inverter_en, 1);
		clu <= 1'b1;
		w(10);
		chk("boost", act.speed_max, 1);
		clu <= 1'b0;
		w(10);
		chk("boost", act.speed_max, 0);
		press(2);
		wi(IND_STOPPING, n);
		wi(IND_STANDBY, n);
		cold <= 1'b0;
		press(2);
		wi(IND_RUNNING, n);
		hot <= 1'b1;
		press(2);
		wi(IND_COOLDOWN, n);
		chk("count", cd >= 1 && cd <= COOL, 1);
		chk("idle", act.speed_idle, 1);
		press(2);
		wi(IND_STOPPING, n);
		chk("early", n < 20, 1);
		wi(IND_STANDBY, n);
		hot <= 1'b0;
		$display("test run done");
		ax(1, CTRL_OFS, 32'h1);
		press(3);
		wi(IND_OFF, n);
		press(3);
		wi(IND_AUTOSTART, n);
		ax(0, STAT_OFS, 0);
		chk("auto", x[7], 1);
		chk("stat", x[3:0], IND_AUTOSTART);
		req <= 1'b1;
		wi(IND_GLOW_PHASE_INDICATION, n);
		chk("delay", inr(n, AUTO_DELAY_S), 1);
		wi(IND_RUNNING, n);
		hot <= 1'b1;
		req <= 1'b0;
		wi(IND_COOLDOWN, n);
		chk("delay", inr(n, AUTO_DELAY_S), 1);
		req <= 1'b1;
		wi(IND_STOPPING, n);
		chk("cool", inr(n, COOL), 1);
		req <= 1'b0;
		hot <= 1'b0;
		wi(IND_AUTOSTART, n);
		press(2);
		wi(IND_RUNNING, n);
		press(2);
		wi(IND_STANDBY, n);
		ax(0, STAT_OFS, 0);
		chk("auto", x[7], 0);
		press(3);
		wi(IND_OFF, n);
		chk("on", con, 0);
		$display("test auto done");
		test_done();
	end
endmodule
